// [design/uhd_pkg.sv]
// Functional notes
// - Divisor registers visible only while format bit7 set
// - Divisor low byte bits 7:0, high 15:8
// - Reset leaves both divisor bytes unset
// - Holding write captured only if room exists
// - Holding-empty sets when shifter takes the byte
// - Holding-empty reads zero while bytes still wait
// - Holding read returns oldest byte and pops it
// - Start falling edge starts 16x tick counter
// - Mid start sample must still be low
// - High mid sample is a false start
// - Receive status shows in line status register
// - Mask register gates three interrupt sources
// - Enabled pending interrupts drive the interrupt pin
// - Data-available interrupt at trigger level in queue mode
// - Data-available interrupt drops below trigger level
// - Source register shows data-available code at trigger
// - Source code clears with interrupt below trigger
// - Data-ready sets when a character enters queue
// - Data-ready clears only when receive queue empties
// - Trigger code 00/01/10/11 gives 1/4/8/14
// - Queue control bit0 enables both queues
// - Holding-empty on status bit5, set when empty
package uhd_pkg;
  // Register addresses on the host bus
  localparam logic [2:0] ADDR_HOLD   = 3'h0;
  localparam logic [2:0] ADDR_MASK   = 3'h1;
  localparam logic [2:0] ADDR_SRC    = 3'h2;
  localparam logic [2:0] ADDR_FORMAT = 3'h3;
  localparam logic [2:0] ADDR_STATUS = 3'h5;
  // Field positions
  localparam int LCR_DIV_ACCESS = 7;
  localparam int FCR_ENABLE     = 0;
  localparam int FCR_RX_CLEAR   = 1;
  localparam int FCR_TX_CLEAR   = 2;
  localparam int FCR_TRIG_LO    = 6;
  localparam int FCR_TRIG_HI    = 7;
  localparam int IER_RX_READY   = 0;
  localparam int IER_TX_EMPTY   = 1;
  localparam int IER_LINE       = 2;
  // Reset values
  localparam logic [7:0] LCR_RESET = 8'h00;
  localparam logic [3:0] IER_RESET = 4'h0;
  // Interrupt source codes
  localparam logic [3:0] SRC_NONE  = 4'h1;
  localparam logic [3:0] SRC_LINE  = 4'h6;
  localparam logic [3:0] SRC_RDA   = 4'h4;
  localparam logic [3:0] SRC_THRE  = 4'h2;
  // Queue sizes and trigger levels
  localparam logic [4:0] DEPTH_QUEUE  = 5'h10;
  localparam logic [4:0] DEPTH_SINGLE = 5'h01;
  localparam logic [4:0] TRIG_00      = 5'h01;
  localparam logic [4:0] TRIG_01      = 5'h04;
  localparam logic [4:0] TRIG_10      = 5'h08;
  localparam logic [4:0] TRIG_11      = 5'h0e;
  // Bit timing in 16x ticks
  localparam logic [3:0] TICK_LAST    = 4'hf;
  localparam logic [3:0] START_MID    = 4'h7;
  localparam logic [2:0] DATA_LAST    = 3'h7;
  localparam logic [3:0] TX_LAST_BIT  = 4'h9;
endpackage : uhd_pkg

// [design/uhd_link_if.sv]
`timescale 1ns/1ps
interface uhd_link_if;
  logic [15:0] divisor;
  logic        tick;
  logic        rx_valid;
  logic [7:0]  rx_data;
  logic        rx_frame_err;
  modport baud (input divisor, output tick);
  modport rx   (input tick, output rx_valid, output rx_data, output rx_frame_err);
  modport core (output divisor, input tick, input rx_valid, input rx_data,
                input rx_frame_err);
endinterface : uhd_link_if

// [design/uhd_baud.sv]
`timescale 1ns/1ps
module uhd_baud (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Divisor in, tick out
  uhd_link_if.baud lnk
);
  typedef struct packed {
    logic [15:0] cnt;
    logic        tick;
  } uhd_baud_s;

  uhd_baud_s s_reg;
  uhd_baud_s s_next;

  // Divide by the divisor; zero behaves like one so the tick never stalls
  always_comb begin
    s_next      = s_reg;
    s_next.tick = 1'b0;
    if ({1'b0, s_reg.cnt} + 17'h1 >= {1'b0, lnk.divisor}) begin
      s_next.cnt  = 16'h0;
      s_next.tick = 1'b1;
    end else begin
      s_next.cnt = s_reg.cnt + 16'h1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign lnk.tick = s_reg.tick;
endmodule : uhd_baud

// [design/uhd_rx.sv]
`timescale 1ns/1ps
module uhd_rx (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Serial input
  input wire logic rxd,
  // Tick in, characters out
  uhd_link_if.rx   lnk
);
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} uhd_rx_e;
  typedef struct packed {
    uhd_rx_e    state;
    logic       rxd_prev;
    logic [3:0] tick_cnt;
    logic [2:0] bit_idx;
    logic [7:0] shreg;
    logic       valid;
    logic [7:0] data;
    logic       ferr;
  } uhd_rx_s;

  uhd_rx_s s_reg;
  uhd_rx_s s_next;

  // Start qualification, then one sample per bit centre
  always_comb begin
    s_next          = s_reg;
    s_next.valid    = 1'b0;
    s_next.rxd_prev = rxd;
    case (s_reg.state)
      RX_IDLE: begin
        if (s_reg.rxd_prev && !rxd) begin
          s_next.state    = RX_START;
          s_next.tick_cnt = 4'h0;
        end
      end
      RX_START: begin
        if (lnk.tick) begin
          if (s_reg.tick_cnt == uhd_pkg::START_MID) begin
            // Glitch shorter than half a bit is dropped here
            if (!rxd) begin
              s_next.state    = RX_DATA;
              s_next.tick_cnt = 4'h0;
              s_next.bit_idx  = 3'h0;
            end else begin
              s_next.state = RX_IDLE;
            end
          end else begin
            s_next.tick_cnt = s_reg.tick_cnt + 4'h1;
          end
        end
      end
      RX_DATA: begin
        if (lnk.tick) begin
          s_next.tick_cnt = s_reg.tick_cnt + 4'h1;
          if (s_reg.tick_cnt == uhd_pkg::TICK_LAST) begin
            s_next.shreg   = {rxd, s_reg.shreg[7:1]};
            s_next.bit_idx = s_reg.bit_idx + 3'h1;
            if (s_reg.bit_idx == uhd_pkg::DATA_LAST) begin
              s_next.state = RX_STOP;
            end
          end
        end
      end
      RX_STOP: begin
        if (lnk.tick) begin
          s_next.tick_cnt = s_reg.tick_cnt + 4'h1;
          if (s_reg.tick_cnt == uhd_pkg::TICK_LAST) begin
            s_next.valid = 1'b1;
            s_next.data  = s_reg.shreg;
            s_next.ferr  = !rxd;
            s_next.state = RX_IDLE;
          end
        end
      end
      default: begin
        s_next.state = RX_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_reg          <= '0;
      s_reg.state    <= RX_IDLE;
      s_reg.rxd_prev <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign lnk.rx_valid     = s_reg.valid;
  assign lnk.rx_data      = s_reg.data;
  assign lnk.rx_frame_err = s_reg.ferr;
endmodule : uhd_rx

// [design/uhd_top.sv]
`timescale 1ns/1ps
module uhd_top (
  // Clock and reset
  input  wire logic       CLK,
  input  wire logic       RESET,
  // Host register bus
  input  wire logic       CS_N,
  input  wire logic       IOR_N,
  input  wire logic       IOW_N,
  input  wire logic [2:0] A,
  input  wire logic [7:0] D_IN,
  output logic      [7:0] D_OUT,
  output logic            D_OE_N,
  // Serial line
  input  wire logic       RXD,
  output logic            TXD,
  // Interrupt to host
  output logic            INT
);
  typedef struct packed {
    logic [7:0]       line_format_control;
    logic [3:0]       irq_mask_reg;
    logic             fifo_en;
    logic [1:0]       trig;
    logic [15:0][7:0] tx_mem;
    logic [3:0]       tx_rd;
    logic [3:0]       tx_wr;
    logic [4:0]       tx_cnt;
    logic [15:0][7:0] rx_mem;
    logic [3:0]       rx_rd;
    logic [3:0]       rx_wr;
    logic [4:0]       rx_cnt;
    logic             overrun;
    logic             framing;
    logic             tx_busy;
    logic [9:0]       tx_frame;
    logic [3:0]       tx_bitn;
    logic [3:0]       tx_tick;
    logic             txd;
    logic             wr_act;
    logic             rd_act;
    logic [7:0]       dout;
    logic             doe_n;
    logic             irq;
  } uhd_top_s;

  uhd_top_s   s_reg;
  uhd_top_s   s_next;
  logic [7:0] div_lo_reg;
  logic [7:0] div_hi_reg;
  logic       wr_stb;
  logic       rd_stb;
  logic       dlab;

  uhd_link_if lnk ();

  uhd_baud u_baud (
    .clk (CLK),
    .rst (RESET),
    .lnk (lnk.baud)
  );

  uhd_rx u_rx (
    .clk (CLK),
    .rst (RESET),
    .rxd (RXD),
    .lnk (lnk.rx)
  );

  assign lnk.divisor = {div_hi_reg, div_lo_reg};

  // Trigger level from the two queue-control bits
  function automatic logic [4:0] trig_level(input logic [1:0] code);
    case (code)
      2'h0:    trig_level = uhd_pkg::TRIG_00;
      2'h1:    trig_level = uhd_pkg::TRIG_01;
      2'h2:    trig_level = uhd_pkg::TRIG_10;
      default: trig_level = uhd_pkg::TRIG_11;
    endcase
  endfunction : trig_level

  // Highest pending enabled source; modem status has no source here
  function automatic logic [3:0] src_code(input uhd_top_s st);
    logic rda;
    rda = st.fifo_en ? (st.rx_cnt >= trig_level(st.trig))
                     : (st.rx_cnt != 5'h0);
    if (st.irq_mask_reg[uhd_pkg::IER_LINE] && (st.overrun || st.framing)) begin
      src_code = uhd_pkg::SRC_LINE;
    end else if (st.irq_mask_reg[uhd_pkg::IER_RX_READY] && rda) begin
      src_code = uhd_pkg::SRC_RDA;
    end else if (st.irq_mask_reg[uhd_pkg::IER_TX_EMPTY] && st.tx_cnt == 5'h0) begin
      src_code = uhd_pkg::SRC_THRE;
    end else begin
      src_code = uhd_pkg::SRC_NONE;
    end
  endfunction : src_code

  // Accesses act once, on the first cycle a strobe is seen low
  assign wr_stb = !CS_N && !IOW_N && !s_reg.wr_act;
  assign rd_stb = !CS_N && !IOR_N && !s_reg.rd_act;
  assign dlab   = s_reg.line_format_control[uhd_pkg::LCR_DIV_ACCESS];

  // Divisor bytes are kept out of reset on purpose
  always_ff @(posedge CLK) begin
    if (wr_stb && dlab && A == uhd_pkg::ADDR_HOLD) begin
      div_lo_reg <= D_IN;
    end
    if (wr_stb && dlab && A == uhd_pkg::ADDR_MASK) begin
      div_hi_reg <= D_IN;
    end
  end

  // Register access, both queues, transmitter and status
  always_comb begin
    logic [4:0] cap;
    logic       tx_pop;
    logic       tx_push;
    logic       rx_push;
    logic       rx_pop;
    logic       hold_wr;
    logic       hold_rd;
    logic       status_rd;
    logic [7:0] line_status_reg;
    cap       = s_reg.fifo_en ? uhd_pkg::DEPTH_QUEUE : uhd_pkg::DEPTH_SINGLE;
    hold_wr   = wr_stb && !dlab && A == uhd_pkg::ADDR_HOLD;
    hold_rd   = rd_stb && !dlab && A == uhd_pkg::ADDR_HOLD;
    status_rd = rd_stb && A == uhd_pkg::ADDR_STATUS;
    // Every local gets a value first so no latch is inferred
    tx_pop    = 1'b0;
    tx_push   = 1'b0;
    rx_push   = 1'b0;
    rx_pop    = 1'b0;
    line_status_reg       = 8'h00;
    s_next    = s_reg;
    s_next.wr_act = !CS_N && !IOW_N;
    s_next.rd_act = !CS_N && !IOR_N;
    s_next.doe_n  = !(!CS_N && !IOR_N);

    // Line status: data ready and holding-empty follow the counts
    line_status_reg = 8'h00;
    line_status_reg[0] = s_reg.rx_cnt != 5'h0;
    line_status_reg[1] = s_reg.overrun;
    line_status_reg[3] = s_reg.framing;
    line_status_reg[5] = s_reg.tx_cnt == 5'h0;
    line_status_reg[6] = (s_reg.tx_cnt == 5'h0) && !s_reg.tx_busy;

    // Read data is latched at the strobe and held while it stays low
    if (rd_stb) begin
      case (A)
        uhd_pkg::ADDR_HOLD:   s_next.dout = dlab ? div_lo_reg : s_reg.rx_mem[s_reg.rx_rd];
        uhd_pkg::ADDR_MASK:   s_next.dout = dlab ? div_hi_reg : {4'h0, s_reg.irq_mask_reg};
        uhd_pkg::ADDR_SRC:    s_next.dout = {{2{s_reg.fifo_en}}, 2'h0, src_code(s_reg)};
        uhd_pkg::ADDR_FORMAT: s_next.dout = s_reg.line_format_control;
        uhd_pkg::ADDR_STATUS: s_next.dout = line_status_reg;
        default:              s_next.dout = 8'h00;
      endcase
    end

    // Transmit: shifter takes the oldest byte as soon as it is idle
    tx_pop  = !s_reg.tx_busy && s_reg.tx_cnt != 5'h0;
    // A write with no room is dropped, so the host must watch the flag
    tx_push = hold_wr && (s_reg.tx_cnt < cap || tx_pop);
    if (tx_push) begin
      s_next.tx_mem[s_reg.tx_wr] = D_IN;
      s_next.tx_wr = s_reg.tx_wr + 4'h1;
    end
    if (tx_pop) begin
      s_next.tx_frame = {1'b1, s_reg.tx_mem[s_reg.tx_rd], 1'b0};
      s_next.tx_rd    = s_reg.tx_rd + 4'h1;
      s_next.tx_busy  = 1'b1;
      s_next.tx_bitn  = 4'h0;
      s_next.tx_tick  = 4'h0;
    end else if (s_reg.tx_busy && lnk.tick) begin
      s_next.tx_tick = s_reg.tx_tick + 4'h1;
      if (s_reg.tx_tick == uhd_pkg::TICK_LAST) begin
        s_next.tx_frame = {1'b1, s_reg.tx_frame[9:1]};
        s_next.tx_bitn  = s_reg.tx_bitn + 4'h1;
        if (s_reg.tx_bitn == uhd_pkg::TX_LAST_BIT) begin
          s_next.tx_busy = 1'b0;
        end
      end
    end
    s_next.tx_cnt = s_reg.tx_cnt + {4'h0, tx_push} - {4'h0, tx_pop};

    // Receive: a full queue keeps its contents and flags overrun
    rx_pop  = hold_rd && s_reg.rx_cnt != 5'h0;
    rx_push = lnk.rx_valid && (s_reg.rx_cnt < cap || rx_pop);
    if (rx_push) begin
      s_next.rx_mem[s_reg.rx_wr] = lnk.rx_data;
      s_next.rx_wr = s_reg.rx_wr + 4'h1;
    end
    if (rx_pop) begin
      s_next.rx_rd = s_reg.rx_rd + 4'h1;
    end
    s_next.rx_cnt = s_reg.rx_cnt + {4'h0, rx_push} - {4'h0, rx_pop};

    // Sticky errors clear on a status read; a new event wins the tie
    s_next.overrun = (s_reg.overrun && !status_rd) || (lnk.rx_valid && !rx_push);
    s_next.framing = (s_reg.framing && !status_rd) || (lnk.rx_valid && lnk.rx_frame_err);

    // Control register writes
    if (wr_stb && !dlab && A == uhd_pkg::ADDR_MASK) begin
      s_next.irq_mask_reg = D_IN[3:0];
    end
    if (wr_stb && A == uhd_pkg::ADDR_FORMAT) begin
      s_next.line_format_control = D_IN;
    end
    if (wr_stb && A == uhd_pkg::ADDR_SRC) begin
      s_next.fifo_en = D_IN[uhd_pkg::FCR_ENABLE];
      // Switching mode flushes both queues so no stale byte survives
      if (D_IN[uhd_pkg::FCR_ENABLE] != s_reg.fifo_en || D_IN[uhd_pkg::FCR_RX_CLEAR]) begin
        s_next.rx_cnt = 5'h0;
        s_next.rx_rd  = 4'h0;
        s_next.rx_wr  = 4'h0;
      end
      if (D_IN[uhd_pkg::FCR_ENABLE] != s_reg.fifo_en || D_IN[uhd_pkg::FCR_TX_CLEAR]) begin
        s_next.tx_cnt = 5'h0;
        s_next.tx_rd  = 4'h0;
        s_next.tx_wr  = 4'h0;
      end
      if (D_IN[uhd_pkg::FCR_ENABLE]) begin
        s_next.trig = D_IN[uhd_pkg::FCR_TRIG_HI:uhd_pkg::FCR_TRIG_LO];
      end
    end

    // Serial output and interrupt pin follow the next state
    s_next.txd = s_next.tx_busy ? s_next.tx_frame[0] : 1'b1;
    s_next.irq = src_code(s_next) != uhd_pkg::SRC_NONE;
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      s_reg       <= '0;
      s_reg.line_format_control   <= uhd_pkg::LCR_RESET;
      s_reg.irq_mask_reg   <= uhd_pkg::IER_RESET;
      s_reg.txd   <= 1'b1;
      s_reg.doe_n <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs straight from state flops
  assign D_OUT  = s_reg.dout;
  assign D_OE_N = s_reg.doe_n;
  assign TXD    = s_reg.txd;
  assign INT    = s_reg.irq;
endmodule : uhd_top

// [sim/uhd_host.sv]
`timescale 1ns/1ps
module uhd_host (
  // Clock and read data
  input  wire logic       CLK,
  input  wire logic [7:0] D_OUT,
  // Host bus strobes and lines
  output logic            CS_N,
  output logic            IOR_N,
  output logic            IOW_N,
  output logic      [2:0] A,
  output logic      [7:0] D_IN
);
  // Bus idle from time zero
  initial begin
    CS_N = 1'b1;
    IOR_N = 1'b1;
    IOW_N = 1'b1;
    A = 3'h7;
    D_IN = 8'h00;
  end
  // Released lines flip, so a stale value is never mistaken for a live one
  task automatic wr(input logic [2:0] adr, input logic [7:0] dat);
    @(posedge CLK);
    #1;
    CS_N = 1'b0;
    IOW_N = 1'b0;
    A = adr;
    D_IN = dat;
    @(posedge CLK);
    #1;
    CS_N = 1'b1;
    IOW_N = 1'b1;
    A = ~adr;
    D_IN = ~dat;
  endtask : wr
  // Read data is taken at the edge after the strobe cycle
  task automatic rd(input logic [2:0] adr, output logic [7:0] dat);
    @(posedge CLK);
    #1;
    CS_N = 1'b0;
    IOR_N = 1'b0;
    A = adr;
    @(posedge CLK);
    #1;
    dat = D_OUT;
    CS_N = 1'b1;
    IOR_N = 1'b1;
    A = ~adr;
  endtask : rd
endmodule : uhd_host

// [sim/uhd_top_chk.sv]
`timescale 1ns/1ps
module uhd_top_chk (
  // Clock and reset
  input wire logic       CLK,
  input wire logic       RESET,
  // Host bus
  input wire logic       CS_N,
  input wire logic       IOR_N,
  input wire logic       IOW_N,
  input wire logic [2:0] A,
  input wire logic [7:0] D_IN,
  input wire logic [7:0] D_OUT,
  input wire logic       D_OE_N,
  // Serial and interrupt
  input wire logic       RXD,
  input wire logic       TXD,
  input wire logic       INT
);
  // Longer than any high run inside a frame for divisors up to 4
  localparam int IDLE_MIN = 700;
  logic       rd_q, wr_q, dlab_q, fen_q;
  logic [3:0] mask_q;
  logic [9:0] idle_q;
  wire        rd_go = !CS_N && !IOR_N && !rd_q;
  wire        wr_go = !CS_N && !IOW_N && !wr_q;
  // Shadows of the control bits that the outputs depend on
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      dlab_q <= 1'b0;
      fen_q <= 1'b0;
      mask_q <= 4'h0;
      idle_q <= 10'h000;
    end else begin
      rd_q <= !CS_N && !IOR_N;
      wr_q <= !CS_N && !IOW_N;
      idle_q <= !TXD ? 10'h000 : idle_q + {9'h000, idle_q != 10'h3ff};
      if (wr_go && A == uhd_pkg::ADDR_FORMAT) dlab_q <= D_IN[uhd_pkg::LCR_DIV_ACCESS];
      if (wr_go && A == uhd_pkg::ADDR_MASK && !dlab_q) mask_q <= D_IN[3:0];
      if (wr_go && A == uhd_pkg::ADDR_SRC) fen_q <= D_IN[uhd_pkg::FCR_ENABLE];
    end
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);
  AST_OE_ON: assert property ((!CS_N && !IOR_N) |=> !D_OE_N)
    else $error("data drive off during read");
  AST_OE_OFF: assert property ((CS_N || IOR_N) |=> D_OE_N)
    else $error("data drive left on");
  AST_DOUT_HOLD: assert property (!rd_go |=> $stable(D_OUT))
    else $error("read data changed without read");
  AST_TX_START: assert property ((wr_go && A == 3'h0 && !dlab_q && idle_q >= IDLE_MIN)
    |-> ##[1:3] (!TXD [*8])) else $error("start bit missing after write");
  AST_INT_MASK: assert property (mask_q == 4'h0 |-> !INT)
    else $error("interrupt with all sources masked");
  AST_SRC_PEND: assert property ((rd_go && A == uhd_pkg::ADDR_SRC)
    |=> D_OUT[0] == !$past(INT)) else $error("source bit0 disagrees with pin");
  AST_SRC_FIFO: assert property ((rd_go && A == uhd_pkg::ADDR_SRC)
    |=> D_OUT[7:6] == {2{fen_q}}) else $error("source mode bits wrong");
  AST_STAT_BITS: assert property ((rd_go && A == uhd_pkg::ADDR_STATUS)
    |=> (!D_OUT[6] || D_OUT[5])) else $error("idle set while queue busy");
  // Main scenarios
  cover property (rd_go && A == uhd_pkg::ADDR_SRC && INT);
  cover property ($fell(TXD));
  cover property (mask_q != 4'h0 && INT);
endmodule : uhd_top_chk
bind uhd_top uhd_top_chk uhd_top_chk_i (.CLK(CLK), .RESET(RESET), .CS_N(CS_N),
  .IOR_N(IOR_N), .IOW_N(IOW_N), .A(A), .D_IN(D_IN), .D_OUT(D_OUT),
  .D_OE_N(D_OE_N), .RXD(RXD), .TXD(TXD), .INT(INT));

// [sim/uhd_top_test.sv]
`timescale 1ns/1ps
module uhd_top_test;
  logic       CLK = 1'b0;
  logic       RESET = 1'b1;
  logic       RXD = 1'b1;
  logic       CS_N, IOR_N, IOW_N, TXD, INT, D_OE_N;
  logic [2:0] A;
  logic [7:0] D_IN, D_OUT, rv, r1, r2;
  int         errors = 0;
  int         samples_checked = 0;
  // Divisor 2: one bit is 32 clocks
  localparam int BITC = 32;
  always #5 CLK = ~CLK;
  uhd_top uhd_top_i (.CLK(CLK), .RESET(RESET), .CS_N(CS_N), .IOR_N(IOR_N),
    .IOW_N(IOW_N), .A(A), .D_IN(D_IN), .D_OUT(D_OUT), .D_OE_N(D_OE_N),
    .RXD(RXD), .TXD(TXD), .INT(INT));
  uhd_host uhd_host_i (.CLK(CLK), .D_OUT(D_OUT), .CS_N(CS_N), .IOR_N(IOR_N),
    .IOW_N(IOW_N), .A(A), .D_IN(D_IN));
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      $display("wrong value at %0t got %h expected %h", $time, got, exp);
      errors++;
    end
  endtask : chk
  task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
    logic [7:0] d;
    uhd_host_i.rd(a, d);
    chk(d, exp);
  endtask : rd_chk
  // Serial frame into the receiver, stop level selectable
  task automatic send(input logic [7:0] b, input logic stp);
    logic [9:0] f;
    f = {stp, b, 1'b0};
    @(posedge CLK);
    #1;
    for (int i = 0; i < 10; i++) begin
      RXD = f[i];
      repeat (BITC) @(posedge CLK);
      #1;
    end
    RXD = 1'b1;
    repeat (4) @(posedge CLK);
    // Step off the edge so outputs read next are settled
    #1;
  endtask : send
  // Sample each transmitted bit at its centre
  task automatic get_tx(output logic [7:0] b);
    @(negedge TXD);
    repeat (BITC / 2) @(posedge CLK);
    for (int i = 0; i < 8; i++) begin
      repeat (BITC) @(posedge CLK);
      #2;
      b[i] = TXD;
    end
    repeat (BITC) @(posedge CLK);
    #2;
    chk({7'h00, TXD}, 8'h01);
  endtask : get_tx
  task automatic t_div();
    uhd_host_i.wr(3'h3, 8'h80);
    uhd_host_i.wr(3'h1, 8'h5a);
    rd_chk(3'h1, 8'h5a);
    uhd_host_i.wr(3'h0, 8'h02);
    uhd_host_i.wr(3'h1, 8'h00);
    rd_chk(3'h0, 8'h02);
    uhd_host_i.wr(3'h3, 8'h03);
    rd_chk(3'h1, 8'h00);
    $display("test divisor done");
  endtask : t_div
  task automatic t_tx();
    repeat (720) @(posedge CLK);
    rd_chk(3'h5, 8'h60);
    fork
      begin
        get_tx(r1);
        get_tx(r2);
      end
      begin
        // Each holding write follows a status read showing room
        uhd_host_i.wr(3'h0, 8'ha5);
        rd_chk(3'h5, 8'h20);
        uhd_host_i.wr(3'h0, 8'h3c);
        rd_chk(3'h5, 8'h00);
      end
    join
    chk(r1, 8'ha5);
    chk(r2, 8'h3c);
    repeat (BITC) @(posedge CLK);
    rd_chk(3'h5, 8'h60);
    $display("test transmit done");
  endtask : t_tx
  task automatic t_rx();
    uhd_host_i.wr(3'h1, 8'h01);
    send(8'h96, 1'b1);
    chk({7'h00, INT}, 8'h01);
    rd_chk(3'h2, 8'h04);
    rd_chk(3'h5, 8'h61);
    rd_chk(3'h0, 8'h96);
    rd_chk(3'h5, 8'h60);
    chk({7'h00, INT}, 8'h00);
    send(8'h55, 1'b0);
    uhd_host_i.rd(3'h5, rv);
    chk(rv & 8'h08, 8'h08);
    uhd_host_i.rd(3'h0, rv);
    $display("test receive done");
  endtask : t_rx
  task automatic t_false();
    @(posedge CLK);
    #1;
    RXD = 1'b0;
    repeat (4) @(posedge CLK);
    #1;
    RXD = 1'b1;
    repeat (12 * BITC) @(posedge CLK);
    rd_chk(3'h5, 8'h60);
    $display("test false start done");
  endtask : t_false
  task automatic t_fifo();
    int tl[4];
    tl = '{1, 4, 8, 14};
    for (int c = 0; c < 4; c++) begin
      uhd_host_i.wr(3'h2, 8'(c << 6) | 8'h03);
      for (int i = 0; i < tl[c]; i++) begin
        chk({7'h00, INT}, 8'h00);
        send(8'(8'h40 + i), 1'b1);
      end
      chk({7'h00, INT}, 8'h01);
    end
    rd_chk(3'h2, 8'hc4);
    rd_chk(3'h0, 8'h40);
    chk({7'h00, INT}, 8'h00);
    rd_chk(3'h2, 8'hc1);
    for (int i = 1; i < 14; i++) begin
      rd_chk(3'h5, 8'h61);
      rd_chk(3'h0, 8'(8'h40 + i));
    end
    rd_chk(3'h5, 8'h60);
    $display("test queue trigger done");
  endtask : t_fifo
  // Main sequence
  initial begin
    repeat (3) @(posedge CLK);
    #1;
    RESET = 1'b0;
    t_div();
    t_tx();
    t_rx();
    t_false();
    t_fifo();
    report_and_stop();
  end
  // Watchdog, well past the expected run length
  initial begin
    repeat (60000) @(posedge CLK);
    errors++;
    report_and_stop();
  end
endmodule : uhd_top_test
